// file: logic/timer8_pkg.sv
// Register map, field layout and mode codes of the 8-bit timer slice
`default_nettype none
package timer8_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CONTROL_A = 8'h44;
    localparam logic [7:0] ADDR_CONTROL_B = 8'h45;
    localparam logic [7:0] ADDR_COUNT = 8'h46;
    localparam logic [7:0] ADDR_COMPARE_A = 8'h47;
    localparam logic [7:0] ADDR_COMPARE_B = 8'h48;
    localparam logic [7:0] ADDR_FLAGS = 8'h35;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h6e;
    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Control A fields
    localparam int CA_OUT_MODE_A_LSB = 6;
    localparam int CA_OUT_MODE_B_LSB = 4;
    localparam int CA_WAVE_LOW_LSB = 0;
    localparam logic [7:0] CA_WRITE_MASK = 8'hf3;
    // Control B fields
    localparam int CB_FORCE_A_BIT = 7;
    localparam int CB_FORCE_B_BIT = 6;
    localparam int CB_WAVE_HIGH_BIT = 3;
    localparam int CB_CLOCK_SEL_LSB = 0;
    localparam logic [7:0] CB_WRITE_MASK = 8'h0f;
    // Flag and mask fields
    localparam int MATCH_B_BIT = 2;
    localparam int MATCH_A_BIT = 1;
    localparam int OVERFLOW_BIT = 0;
    localparam logic [7:0] IRQ_WRITE_MASK = 8'h07;
    // Counter limits
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    // Clock select codes
    localparam logic [2:0] CS_STOPPED = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // Prescaler tap masks: all ones below the tap means the rate is due
    localparam logic [9:0] PRE_MASK_8 = 10'h007;
    localparam logic [9:0] PRE_MASK_64 = 10'h03f;
    localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
    localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;
    // Waveform mode codes
    localparam logic [2:0] WM_NORMAL = 3'h0;
    localparam logic [2:0] WM_PHASE_FF = 3'h1;
    localparam logic [2:0] WM_CTC = 3'h2;
    localparam logic [2:0] WM_FAST_FF = 3'h3;
    localparam logic [2:0] WM_PHASE_OCA = 3'h5;
    localparam logic [2:0] WM_FAST_OCA = 3'h7;
    // Compare output mode codes
    localparam logic [1:0] OM_OFF = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR = 2'h2;
    localparam logic [1:0] OM_SET = 2'h3;
    typedef enum logic [1:0] {
        KIND_PLAIN,
        KIND_FAST,
        KIND_PHASE
    } wave_kind_t;
endpackage
`default_nettype wire

// file: logic/timer8_control_compare_regs.sv
// Control, counter, compare and interrupt-enable slice of an 8-bit timer
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module timer8_control_compare_regs (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    output logic [7:0] rdata_out,
    input wire logic external_count_pin_in,
    input wire logic global_irq_enable_in,
    input wire logic vector_ack_match_a_in,
    input wire logic vector_ack_match_b_in,
    input wire logic vector_ack_overflow_in,
    output logic irq_match_a_out,
    output logic irq_match_b_out,
    output logic irq_overflow_out,
    output logic wave_out_a_out,
    output logic wave_out_b_out,
    output logic wave_enable_a_out,
    output logic wave_enable_b_out
);
    // Classify the three-bit waveform mode
    function automatic timer8_pkg::wave_kind_t kind_of(
        input logic [2:0] mode
    );
        if (mode == timer8_pkg::WM_PHASE_FF ||
            mode == timer8_pkg::WM_PHASE_OCA) begin
            kind_of = timer8_pkg::KIND_PHASE;
        end else if (mode == timer8_pkg::WM_FAST_FF ||
                     mode == timer8_pkg::WM_FAST_OCA) begin
            kind_of = timer8_pkg::KIND_FAST;
        end else begin
            kind_of = timer8_pkg::KIND_PLAIN;
        end
    endfunction

    // Next level of one waveform output
    function automatic logic wave_next(
        input logic cur,
        input logic [1:0] om,
        input timer8_pkg::wave_kind_t kind,
        input logic toggle_ok,
        input logic hit,
        input logic force_hit,
        input logic wrap,
        input logic going_up
    );
        wave_next = cur;
        case (kind)
            timer8_pkg::KIND_PLAIN: begin
                if (hit || force_hit) begin
                    case (om)
                        timer8_pkg::OM_TOGGLE: wave_next = ~cur;
                        timer8_pkg::OM_CLEAR: wave_next = 1'b0;
                        timer8_pkg::OM_SET: wave_next = 1'b1;
                        default: wave_next = cur;
                    endcase
                end
            end
            timer8_pkg::KIND_FAST: begin
                if (om == timer8_pkg::OM_CLEAR) begin
                    if (hit) begin
                        wave_next = 1'b0;
                    end else if (wrap) begin
                        wave_next = 1'b1;
                    end
                end else if (om == timer8_pkg::OM_SET) begin
                    if (hit) begin
                        wave_next = 1'b1;
                    end else if (wrap) begin
                        wave_next = 1'b0;
                    end
                end else if (om == timer8_pkg::OM_TOGGLE && toggle_ok) begin
                    if (hit) begin
                        wave_next = ~cur;
                    end
                end
            end
            default: begin
                if (om == timer8_pkg::OM_CLEAR && hit) begin
                    wave_next = ~going_up;
                end else if (om == timer8_pkg::OM_SET && hit) begin
                    wave_next = going_up;
                end else if (om == timer8_pkg::OM_TOGGLE && toggle_ok) begin
                    if (hit) begin
                        wave_next = ~cur;
                    end
                end
            end
        endcase
    endfunction

    logic [7:0] control_a_q;
    logic [3:0] control_b_q;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] compare_a_q;
    logic [7:0] compare_b_q;
    logic [2:0] flags_q;
    logic [2:0] flags_d;
    logic [2:0] mask_q;
    logic [7:0] rdata_q;
    logic [9:0] prescale_q;
    logic pin_meta_q;
    logic pin_sync_q;
    logic pin_prev_q;
    logic up_q;
    logic up_d;
    logic block_q;
    logic wave_a_q;
    logic wave_b_q;

    // Register decode
    wire logic hit_ca = addr_in == timer8_pkg::ADDR_CONTROL_A;
    wire logic hit_cb = addr_in == timer8_pkg::ADDR_CONTROL_B;
    wire logic hit_cnt = addr_in == timer8_pkg::ADDR_COUNT;
    wire logic hit_oa = addr_in == timer8_pkg::ADDR_COMPARE_A;
    wire logic hit_ob = addr_in == timer8_pkg::ADDR_COMPARE_B;
    wire logic hit_fl = addr_in == timer8_pkg::ADDR_FLAGS;
    wire logic hit_im = addr_in == timer8_pkg::ADDR_IRQ_MASK;
    wire logic wr_ca = write_in && hit_ca;
    wire logic wr_cb = write_in && hit_cb;
    wire logic wr_cnt = write_in && hit_cnt;
    wire logic wr_fl = write_in && hit_fl;

    // Mode fields
    wire logic [1:0] out_mode_a =
        control_a_q[timer8_pkg::CA_OUT_MODE_A_LSB +: 2];
    wire logic [1:0] out_mode_b =
        control_a_q[timer8_pkg::CA_OUT_MODE_B_LSB +: 2];
    wire logic [1:0] wave_mode_low_bits =
        control_a_q[timer8_pkg::CA_WAVE_LOW_LSB +: 2];
    wire logic wave_mode_high_bit =
        control_b_q[timer8_pkg::CB_WAVE_HIGH_BIT];
    wire logic [2:0] clock_select =
        control_b_q[timer8_pkg::CB_CLOCK_SEL_LSB +: 3];
    wire logic [2:0] wave_mode = {wave_mode_high_bit,
        wave_mode_low_bits};
    wire timer8_pkg::wave_kind_t kind = kind_of(wave_mode);
    wire logic top_is_oca = wave_mode == timer8_pkg::WM_CTC ||
        wave_mode == timer8_pkg::WM_PHASE_OCA ||
        wave_mode == timer8_pkg::WM_FAST_OCA;
    wire logic [7:0] top = top_is_oca ? compare_a_q :
        timer8_pkg::COUNT_MAX;
    wire logic at_top = count_q == top;
    wire logic at_max = count_q == timer8_pkg::COUNT_MAX;
    wire logic at_bottom = count_q == timer8_pkg::COUNT_BOTTOM;

    // Force strobes: one cycle, only outside PWM modes
    wire logic force_a = wr_cb && wdata_in[timer8_pkg::CB_FORCE_A_BIT] &&
        kind == timer8_pkg::KIND_PLAIN;
    wire logic force_b = wr_cb && wdata_in[timer8_pkg::CB_FORCE_B_BIT] &&
        kind == timer8_pkg::KIND_PLAIN;

    // Timer clock enable
    // The pin is sampled regardless of its port direction
    wire logic pin_rise = pin_sync_q && !pin_prev_q;
    wire logic pin_fall = !pin_sync_q && pin_prev_q;
    logic tick;
    always_comb begin
        tick = 1'b0;
        case (clock_select)
            timer8_pkg::CS_STOPPED: tick = 1'b0;
            timer8_pkg::CS_DIV1: tick = 1'b1;
            timer8_pkg::CS_DIV8: tick =
                (prescale_q & timer8_pkg::PRE_MASK_8) ==
                timer8_pkg::PRE_MASK_8;
            timer8_pkg::CS_DIV64: tick =
                (prescale_q & timer8_pkg::PRE_MASK_64) ==
                timer8_pkg::PRE_MASK_64;
            timer8_pkg::CS_DIV256: tick =
                (prescale_q & timer8_pkg::PRE_MASK_256) ==
                timer8_pkg::PRE_MASK_256;
            timer8_pkg::CS_DIV1024: tick =
                (prescale_q & timer8_pkg::PRE_MASK_1024) ==
                timer8_pkg::PRE_MASK_1024;
            timer8_pkg::CS_EXT_FALL: tick = pin_fall;
            default: tick = pin_rise;
        endcase
    end

    // Compare events, suppressed on the tick after a counter write
    wire logic match_a = tick && !block_q && !wr_cnt &&
        count_q == compare_a_q;
    wire logic match_b = tick && !block_q && !wr_cnt &&
        count_q == compare_b_q;

    // Count sequence
    logic overflow;
    logic wrap;
    always_comb begin
        count_d = count_q;
        up_d = up_q;
        overflow = 1'b0;
        wrap = 1'b0;
        if (wr_cnt) begin
            count_d = wdata_in;
        end else if (tick) begin
            case (kind)
                timer8_pkg::KIND_PHASE: begin
                    if (up_q && at_top) begin
                        up_d = 1'b0;
                        count_d = count_q - 8'h01;
                    end else if (!up_q && at_bottom) begin
                        up_d = 1'b1;
                        overflow = 1'b1;
                        count_d = count_q + 8'h01;
                    end else if (up_q) begin
                        count_d = count_q + 8'h01;
                    end else begin
                        count_d = count_q - 8'h01;
                    end
                end
                timer8_pkg::KIND_FAST: begin
                    up_d = 1'b1;
                    if (at_top) begin
                        count_d = timer8_pkg::COUNT_BOTTOM;
                        overflow = 1'b1;
                        wrap = 1'b1;
                    end else begin
                        count_d = count_q + 8'h01;
                    end
                end
                default: begin
                    up_d = 1'b1;
                    // Only a real match clears in CTC, never a force
                    if (wave_mode == timer8_pkg::WM_CTC && match_a) begin
                        count_d = timer8_pkg::COUNT_BOTTOM;
                    end else begin
                        count_d = count_q + 8'h01;
                    end
                    overflow = at_max;
                end
            endcase
        end
    end

    // Flags: hardware set beats both clears in the same cycle
    wire logic [2:0] flag_set = {match_b, match_a, overflow};
    wire logic [2:0] flag_clr = ({3{wr_fl}} & wdata_in[2:0]) |
        {vector_ack_match_b_in, vector_ack_match_a_in,
        vector_ack_overflow_in};
    assign flags_d = flag_set | (flags_q & ~flag_clr);

    // Read multiplexer, reserved and force bits read zero
    logic [7:0] read_mux;
    always_comb begin
        if (hit_ca) begin
            read_mux = control_a_q & timer8_pkg::CA_WRITE_MASK;
        end else if (hit_cb) begin
            read_mux = {4'h0, control_b_q};
        end else if (hit_cnt) begin
            read_mux = count_q;
        end else if (hit_oa) begin
            read_mux = compare_a_q;
        end else if (hit_ob) begin
            read_mux = compare_b_q;
        end else if (hit_fl) begin
            read_mux = {5'h00, flags_q};
        end else if (hit_im) begin
            read_mux = {5'h00, mask_q};
        end else begin
            read_mux = timer8_pkg::RESET_BYTE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            control_a_q <= timer8_pkg::RESET_BYTE;
            control_b_q <= 4'h0;
            compare_a_q <= timer8_pkg::RESET_BYTE;
            compare_b_q <= timer8_pkg::RESET_BYTE;
            mask_q <= 3'h0;
        end else if (write_in) begin
            if (hit_ca) begin
                control_a_q <= wdata_in & timer8_pkg::CA_WRITE_MASK;
            end
            if (hit_cb) begin
                control_b_q <= wdata_in[3:0];
            end
            if (hit_oa) begin
                compare_a_q <= wdata_in;
            end
            if (hit_ob) begin
                compare_b_q <= wdata_in;
            end
            if (hit_im) begin
                mask_q <= wdata_in[2:0];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_q <= timer8_pkg::RESET_BYTE;
            up_q <= 1'b1;
            flags_q <= 3'h0;
            block_q <= 1'b0;
        end else begin
            count_q <= count_d;
            up_q <= up_d;
            flags_q <= flags_d;
            // Held until the next timer tick after a counter write
            if (wr_cnt) begin
                block_q <= 1'b1;
            end else if (tick) begin
                block_q <= 1'b0;
            end
        end
    end

    // Shared prescaler runs free; the pin synchroniser feeds an edge stage
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prescale_q <= 10'h000;
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            prescale_q <= prescale_q + 10'h001;
            pin_meta_q <= external_count_pin_in;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wave_a_q <= 1'b0;
            wave_b_q <= 1'b0;
        end else begin
            wave_a_q <= wave_next(wave_a_q, out_mode_a, kind,
                wave_mode_high_bit, match_a, force_a, wrap,
                up_q);
            wave_b_q <= wave_next(wave_b_q, out_mode_b, kind,
                1'b0, match_b, force_b, wrap, up_q);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_q <= timer8_pkg::RESET_BYTE;
        end else if (read_in) begin
            rdata_q <= read_mux;
        end else begin
            rdata_q <= timer8_pkg::RESET_BYTE;
        end
    end

    assign rdata_out = rdata_q;
    assign irq_match_b_out = global_irq_enable_in &&
        mask_q[timer8_pkg::MATCH_B_BIT] &&
        flags_q[timer8_pkg::MATCH_B_BIT];
    assign irq_match_a_out = global_irq_enable_in &&
        mask_q[timer8_pkg::MATCH_A_BIT] &&
        flags_q[timer8_pkg::MATCH_A_BIT];
    assign irq_overflow_out = global_irq_enable_in &&
        mask_q[timer8_pkg::OVERFLOW_BIT] &&
        flags_q[timer8_pkg::OVERFLOW_BIT];
    assign wave_out_a_out = wave_a_q;
    assign wave_out_b_out = wave_b_q;
    assign wave_enable_a_out = out_mode_a != timer8_pkg::OM_OFF;
    assign wave_enable_b_out = out_mode_b != timer8_pkg::OM_OFF;
endmodule // timer8_control_compare_regs

`default_nettype wire

// file: dv/timer8_regs_sva.sv
// Port checker for the 8-bit timer register slice
`timescale 1ns/1ns
`default_nettype none
module timer8_regs_sva (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    input wire logic [7:0] rdata_out,
    input wire logic global_irq_enable_in,
    input wire logic irq_match_a_out,
    input wire logic irq_match_b_out,
    input wire logic irq_overflow_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    logic [2:0] mask_q;
    logic [2:0] cs_q;
    logic [7:0] cnt_q;
    logic ran_q;
    wire wr_cb = write_in && addr_in == timer8_pkg::ADDR_CONTROL_B;
    wire wr_cnt = write_in && addr_in == timer8_pkg::ADDR_COUNT;
    wire wr_msk = write_in && addr_in == timer8_pkg::ADDR_IRQ_MASK;
    wire rd_cnt = read_in && addr_in == timer8_pkg::ADDR_COUNT;
    // Shadow of the count is only trusted while no clock was selected
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mask_q <= 3'h0;
            cs_q <= 3'h0;
            cnt_q <= 8'h00;
            ran_q <= 1'b0;
        end else begin
            if (wr_msk) mask_q <= wdata_in[2:0];
            if (wr_cb) cs_q <= wdata_in[2:0];
            if (wr_cnt) cnt_q <= wdata_in;
            if (wr_cnt && cs_q == 3'h0) ran_q <= 1'b0;
            else if (cs_q != 3'h0) ran_q <= 1'b1;
        end
    end
    cb_read_zero_a: assert property (
        read_in && addr_in == timer8_pkg::ADDR_CONTROL_B
        |=> rdata_out[7:4] == 4'h0) else $error("control b top bits set");
    mask_read_zero_a: assert property (
        read_in && addr_in == timer8_pkg::ADDR_IRQ_MASK
        |=> rdata_out[7:3] == 5'h00) else $error("mask top bits set");
    unmapped_zero_a: assert property (
        read_in && addr_in[7:4] == 4'h5 |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    count_hold_a: assert property (
        rd_cnt && !ran_q |=> rdata_out == $past(cnt_q))
        else $error("stopped count moved");
    count_write_a: assert property (
        wr_cnt ##1 rd_cnt |=> rdata_out == $past(wdata_in, 2))
        else $error("count readback wrong");
    irq_b_gate_a: assert property (
        irq_match_b_out |-> global_irq_enable_in && mask_q[2])
        else $error("match b irq without enables");
    irq_a_gate_a: assert property (
        irq_match_a_out |-> global_irq_enable_in && mask_q[1])
        else $error("match a irq without enables");
    irq_ovf_gate_a: assert property (
        irq_overflow_out |-> global_irq_enable_in && mask_q[0])
        else $error("overflow irq without enables");
    cover property (irq_match_a_out && irq_match_b_out);
    cover property (irq_overflow_out);
    cover property (rd_cnt && !ran_q);
endmodule // timer8_regs_sva
bind timer8_control_compare_regs timer8_regs_sva i_sva (.clk_in, .rst_in,
    .addr_in, .wdata_in, .write_in, .read_in, .rdata_out,
    .global_irq_enable_in, .irq_match_a_out, .irq_match_b_out,
    .irq_overflow_out);
`default_nettype wire

// file: dv/test_timer8_control_compare_regs.sv
// Self-checking bench for the 8-bit timer register slice
`timescale 1ns/1ns
`default_nettype none
module test_timer8_control_compare_regs;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic pin = 1'b0;
    logic gie = 1'b0;
    logic ack_a = 1'b0;
    logic ack_b = 1'b0;
    logic ack_ovf = 1'b0;
    logic [7:0] rdata;
    logic irq_a;
    logic irq_b;
    logic irq_ovf;
    logic wave_a;
    logic wave_b;
    logic en_a;
    logic en_b;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    always #10 clk_in = ~clk_in;
    timer8_control_compare_regs i_dut (.clk_in(clk_in), .rst_in(rst_in),
        .addr_in(addr), .wdata_in(wdata), .write_in(wr_en),
        .read_in(rd_en), .rdata_out(rdata), .external_count_pin_in(pin),
        .global_irq_enable_in(gie), .vector_ack_match_a_in(ack_a),
        .vector_ack_match_b_in(ack_b), .vector_ack_overflow_in(ack_ovf),
        .irq_match_a_out(irq_a), .irq_match_b_out(irq_b),
        .irq_overflow_out(irq_ovf), .wave_out_a_out(wave_a),
        .wave_out_b_out(wave_b), .wave_enable_a_out(en_a),
        .wave_enable_b_out(en_b));
    task automatic complete_run();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Sized for the whole run, all five prescaler windows included, plus margin
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end
    task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bus tasks are entered just after a rising edge
    task automatic wr(logic [7:0] a, logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_in);
        wr_en <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rchk(string what, logic [7:0] a, logic [7:0] exp);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_in);
        rd_en <= 1'b0;
        @(negedge clk_in);
        check8(what, exp, rdata);
        @(posedge clk_in);
    endtask
    // Read issued in the cycle right after the write
    task automatic wchk(logic [7:0] a, logic [7:0] d, logic [7:0] exp);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_in);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clk_in);
        rd_en <= 1'b0;
        @(negedge clk_in);
        check8("readback", exp, rdata);
        @(posedge clk_in);
    endtask
    // Select order is match b, match a, overflow
    task automatic pulse_ack(logic [2:0] sel);
        {ack_b, ack_a, ack_ovf} <= sel;
        @(posedge clk_in);
        {ack_b, ack_a, ack_ovf} <= 3'h0;
        @(posedge clk_in);
    endtask
    task automatic t_reset();
        logic [7:0] map [7] = '{8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h35,
            8'h6e};
        for (int i = 0; i < 7; i++) begin
            rchk("reset value", map[i], 8'h00);
        end
        check8("reset irqs", 8'h00, {5'h00, irq_a, irq_b, irq_ovf});
        check8("reset wave", 8'h00, {4'h0, wave_a, wave_b, en_a, en_b});
    endtask
    task automatic t_regs();
        wchk(timer8_pkg::ADDR_COMPARE_A, 8'ha5, 8'ha5);
        wchk(timer8_pkg::ADDR_COMPARE_B, 8'h5a, 8'h5a);
        wchk(timer8_pkg::ADDR_IRQ_MASK, 8'hff, 8'h07);
        wchk(8'h50, 8'hff, 8'h00);
        wchk(timer8_pkg::ADDR_CONTROL_B, 8'hf8, 8'h08);
        wchk(timer8_pkg::ADDR_COUNT, 8'h3c, 8'h3c);
        repeat (20) @(posedge clk_in);
        rchk("stopped count", timer8_pkg::ADDR_COUNT, 8'h3c);
        wr(timer8_pkg::ADDR_CONTROL_B, 8'h00);
        wr(timer8_pkg::ADDR_IRQ_MASK, 8'h00);
    endtask
    // Four ticks per window whatever the free prescaler phase
    task automatic t_prescale();
        int div [5] = '{1, 8, 64, 256, 1024};
        for (int i = 0; i < 5; i++) begin
            wr(timer8_pkg::ADDR_COUNT, 8'h00);
            wr(timer8_pkg::ADDR_CONTROL_B, 8'(i + 1));
            repeat (4 * div[i] - 2) @(posedge clk_in);
            wr(timer8_pkg::ADDR_CONTROL_B, 8'h00);
            rchk("prescaled count", timer8_pkg::ADDR_COUNT, 8'h04);
        end
    endtask
    task automatic t_pin(logic [2:0] cs);
        wr(timer8_pkg::ADDR_COUNT, 8'h00);
        wr(timer8_pkg::ADDR_CONTROL_B, {5'h00, cs});
        repeat (5) begin
            pin <= 1'b1;
            repeat (4) @(posedge clk_in);
            pin <= 1'b0;
            repeat (4) @(posedge clk_in);
        end
        wr(timer8_pkg::ADDR_CONTROL_B, 8'h00);
        rchk("pin count", timer8_pkg::ADDR_COUNT, 8'h05);
    endtask
    task automatic t_block();
        wr(timer8_pkg::ADDR_COMPARE_A, 8'h02);
        wr(timer8_pkg::ADDR_COUNT, 8'h02);
        wr(timer8_pkg::ADDR_CONTROL_B, 8'h01);
        wr(timer8_pkg::ADDR_CONTROL_B, 8'h00);
        rchk("count", timer8_pkg::ADDR_COUNT, 8'h04);
        rchk("blocked match", timer8_pkg::ADDR_FLAGS, 8'h00);
    endtask
    task automatic t_match();
        wr(timer8_pkg::ADDR_IRQ_MASK, 8'h07);
        gie <= 1'b1;
        wr(timer8_pkg::ADDR_COMPARE_A, 8'h03);
        wr(timer8_pkg::ADDR_COMPARE_B, 8'h05);
        wr(timer8_pkg::ADDR_COUNT, 8'h00);
        wr(timer8_pkg::ADDR_CONTROL_B, 8'h01);
        repeat (8) @(posedge clk_in);
        wr(timer8_pkg::ADDR_CONTROL_B, 8'h00);
        rchk("match flags", timer8_pkg::ADDR_FLAGS, 8'h06);
        check8("irq a", 8'h01, {7'h00, irq_a});
        check8("irq b", 8'h01, {7'h00, irq_b});
        check8("irq ovf", 8'h00, {7'h00, irq_ovf});
        gie <= 1'b0;
        @(negedge clk_in);
        check8("irq a gated", 8'h00, {7'h00, irq_a});
        check8("irq b gated", 8'h00, {7'h00, irq_b});
        @(posedge clk_in);
        gie <= 1'b1;
        wr(timer8_pkg::ADDR_FLAGS, 8'h04);
        rchk("write one clear", timer8_pkg::ADDR_FLAGS, 8'h02);
        pulse_ack(3'h2);
        rchk("vector clear", timer8_pkg::ADDR_FLAGS, 8'h00);
        check8("irq a cleared", 8'h00, {7'h00, irq_a});
        wr(timer8_pkg::ADDR_COUNT, 8'hfd);
        wr(timer8_pkg::ADDR_CONTROL_B, 8'h01);
        repeat (2) @(posedge clk_in);
        wr(timer8_pkg::ADDR_CONTROL_B, 8'h00);
        rchk("overflow flag", timer8_pkg::ADDR_FLAGS, 8'h01);
        check8("irq ovf", 8'h01, {7'h00, irq_ovf});
        wr(timer8_pkg::ADDR_IRQ_MASK, 8'h06);
        check8("irq ovf masked", 8'h00, {7'h00, irq_ovf});
        pulse_ack(3'h1);
        pulse_ack(3'h4);
        rchk("ack clear", timer8_pkg::ADDR_FLAGS, 8'h00);
    endtask
    task automatic t_force();
        wr(timer8_pkg::ADDR_CONTROL_A, 8'h70);
        wr(timer8_pkg::ADDR_CONTROL_B, 8'hc0);
        rchk("force reads", timer8_pkg::ADDR_CONTROL_B, 8'h00);
        check8("forced toggle a", 8'h01, {7'h00, wave_a});
        check8("forced set b", 8'h01, {7'h00, wave_b});
        check8("enables", 8'h03, {6'h00, en_a, en_b});
        rchk("force flags", timer8_pkg::ADDR_FLAGS, 8'h00);
        wr(timer8_pkg::ADDR_CONTROL_A, 8'ha2);
        wr(timer8_pkg::ADDR_CONTROL_B, 8'hc0);
        rchk("no clear", timer8_pkg::ADDR_COUNT, 8'h01);
        check8("forced clear", 8'h00, {6'h00, wave_a, wave_b});
        // Breaks the software zero-write advice on purpose
        wr(timer8_pkg::ADDR_CONTROL_A, 8'hf3);
        wr(timer8_pkg::ADDR_CONTROL_B, 8'hc8);
        rchk("pwm force", timer8_pkg::ADDR_FLAGS, 8'h00);
        check8("pwm waves", 8'h00, {6'h00, wave_a, wave_b});
        wr(timer8_pkg::ADDR_CONTROL_B, 8'h00);
        wr(timer8_pkg::ADDR_CONTROL_A, 8'h00);
        check8("released", 8'h00, {6'h00, en_a, en_b});
    endtask
    // Ten ticks from zero with compare a at 3 wrap twice in CTC
    task automatic t_ctc();
        wr(timer8_pkg::ADDR_CONTROL_A, 8'h02);
        wr(timer8_pkg::ADDR_COMPARE_A, 8'h03);
        wr(timer8_pkg::ADDR_COUNT, 8'h00);
        wr(timer8_pkg::ADDR_CONTROL_B, 8'h01);
        repeat (8) @(posedge clk_in);
        wr(timer8_pkg::ADDR_CONTROL_B, 8'h00);
        rchk("ctc count", timer8_pkg::ADDR_COUNT, 8'h02);
        rchk("ctc flags", timer8_pkg::ADDR_FLAGS, 8'h02);
        wr(timer8_pkg::ADDR_FLAGS, 8'h07);
        wr(timer8_pkg::ADDR_CONTROL_A, 8'h00);
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        t_reset();
        t_regs();
        t_prescale();
        t_pin(timer8_pkg::CS_EXT_FALL);
        t_pin(timer8_pkg::CS_EXT_RISE);
        t_block();
        t_match();
        t_force();
        t_ctc();
        complete_run();
    end
endmodule // test_timer8_control_compare_regs
`default_nettype wire
